// ===== src/isd_top.sv
// logic-side diagnostic reporting and link watchdog for an isolated switch
`timescale 1ns/1ps
module isd_top
  import isd_pkg::*;
#(
  parameter int unsigned LINK_TIMEOUT = LINK_TIMEOUT_CYC
) (
  // system clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  // link clock and its reset
  input wire logic i_clk_link,
  input wire logic i_rstn_link,
  // frames from the switch side
  input wire logic i_frame_valid,
  input wire isd_pkg::isd_frame_type i_frame,
  // heartbeat towards the switch side
  output logic o_link_heartbeat,
  // channel commands
  input wire logic [isd_pkg::NCH-1:0] i_parallel_channel_input,
  input wire logic [isd_pkg::NCH-1:0] i_switch_on_command,
  output logic [isd_pkg::NCH-1:0] o_switch_output_channel,
  // chain address strap
  input wire logic [isd_pkg::CHAIN_AW-1:0] i_chain_addr_strap,
  // register read and report clear
  input wire logic i_rd_en,
  input wire logic [isd_pkg::CHAIN_AW-1:0] i_rd_dev,
  input wire logic [1:0] i_rd_addr,
  output logic o_rd_valid,
  output logic [7:0] o_rd_data,
  input wire logic i_clr_en,
  input wire logic [isd_pkg::CHAIN_AW-1:0] i_clr_dev,
  // register contents
  output logic [7:0] o_top_diagnostic_register,
  output logic [7:0] o_per_channel_diagnostic_register_b21,
  output logic [7:0] o_per_channel_diagnostic_register_b43,
  output logic [7:0] o_switch_output_state,
  // open-drain indicators, low-drive value and enable
  output logic o_open_load_indicator_pin_o,
  output logic o_open_load_indicator_pin_oe,
  output logic [isd_pkg::NCH-1:0] o_channel_state_indicator_pin_o,
  output logic [isd_pkg::NCH-1:0] o_channel_state_indicator_pin_oe
);
  import isd_pkg::*;

  // link side crossing
  logic link_req;
  isd_word_type link_word;
  logic link_ack;
  logic link_ack_sync;
  logic req_sync;

  isd_link_rx u_link_rx (
    .i_clk_link(i_clk_link),
    .i_rstn_link(i_rstn_link),
    .i_frame_valid(i_frame_valid),
    .i_frame(i_frame),
    .i_ack_sync(link_ack_sync),
    .o_req(link_req),
    .o_word(link_word)
  );

  isd_sync #(.W(1)) u_ack_sync (
    .i_clk(i_clk_link),
    .i_rstn(i_rstn_link),
    .i_d(link_ack),
    .o_q(link_ack_sync)
  );

  isd_sync #(.W(1)) u_req_sync (
    .i_clk(i_clk_sys),
    .i_rstn(i_rstn),
    .i_d(link_req),
    .o_q(req_sync)
  );

  // pins from outside the system clock
  logic [NCH-1:0] par_in;
  logic [CHAIN_AW-1:0] strap_in;

  isd_sync #(.W(NCH)) u_par_sync (
    .i_clk(i_clk_sys),
    .i_rstn(i_rstn),
    .i_d(i_parallel_channel_input),
    .o_q(par_in)
  );

  isd_sync #(.W(CHAIN_AW)) u_strap_sync (
    .i_clk(i_clk_sys),
    .i_rstn(i_rstn),
    .i_d(i_chain_addr_strap),
    .o_q(strap_in)
  );

  // system side state
  logic [TO_W-1:0] silence;
  logic timed_out;
  isd_link_state_type state;
  isd_link_state_type next_state;
  logic [NCH-1:0] open_flag;
  logic [NCH-1:0] next_open_flag;
  logic [NCH-1:0] out_state;
  logic [NCH-1:0] over_current;
  logic [CHAIN_AW-1:0] chain_addr;
  logic strap_taken;
  logic [1:0] strap_wait;

  // decode
  wire new_word;
  wire link_cause;
  wire clr_hit;
  wire rd_hit;
  wire next_fault;
  wire [NCH-1:0] cmd_on;
  wire [NCH-1:0] open_meas;
  wire [NCH-1:0] next_out_state;
  wire [NCH-1:0] next_drive;
  wire [NCH-1:0] next_over_current;
  wire [NCH-1:0] chan_per_channel_diagnostic_register;
  wire [7:0] next_top;
  wire [7:0] next_b21;
  wire [7:0] next_b43;
  wire [7:0] next_stat;
  wire [7:0] rd_mux;
  wire sel_top;
  wire sel_b21;
  wire sel_b43;

  // req and ack differ while a word waits to be taken
  assign new_word = (req_sync != link_ack);
  // commanded on from either the pins or the software command, bit 0 is channel 1
  assign cmd_on = par_in | i_switch_on_command;
  // bad parity, remote report or silence all count as link error
  assign link_cause = (new_word && (link_word.bad || link_word.frame.remote_err))
                      || timed_out;
  assign clr_hit = i_clr_en && strap_taken && (i_clr_dev == chain_addr);
  assign rd_hit = i_rd_en && strap_taken && (i_rd_dev == chain_addr);

  // link fault sequencing
  always_comb begin
    next_state = state;
    unique case (state)
      ST_RUN: begin
        if (link_cause) begin
          next_state = ST_FAULT;
        end
      end
      ST_FAULT: begin
        // clear is ignored while the cause persists
        if (!link_cause) begin
          next_state = ST_HELD;
        end
      end
      ST_HELD: begin
        // a new cause wins over a clear in the same cycle
        if (link_cause) begin
          next_state = ST_FAULT;
        end else if (clr_hit) begin
          next_state = ST_RUN;
        end
      end
      default: begin
        next_state = ST_FAULT;
      end
    endcase
  end

  assign next_fault = (next_state != ST_RUN);

  // open-load measurement from the newest frame, off channels only
  assign open_meas = (new_word && !link_word.bad) ? (link_word.frame.open_meas & ~cmd_on)
                     : '0;

  always_comb begin
    next_open_flag = open_flag;
    for (int i = 0; i < NCH; i++) begin
      if (cmd_on[i]) begin
        next_open_flag[i] = 1'b0;
      end else if (open_meas[i]) begin
        next_open_flag[i] = 1'b1;
      end else if (clr_hit) begin
        next_open_flag[i] = 1'b0;
      end
    end
  end

  // actual output state as reported, forced off while the link is down
  assign next_out_state = next_fault ? '0
                          : ((new_word && !link_word.bad) ? link_word.frame.out_state
                             : out_state);
  // drive taken from next fault so shutdown needs no extra cycle
  assign next_drive = next_fault ? '0 : cmd_on;

  // over-current kept only for channels commanded on
  assign next_over_current = (new_word && !link_word.bad)
                             ? (link_word.frame.over_current & cmd_on) : over_current;
  // summary bits use the same next values as the channel registers
  assign chan_per_channel_diagnostic_register = next_open_flag | next_over_current;
  assign next_top = {next_fault, 3'h0, chan_per_channel_diagnostic_register};
  assign next_b21 = {next_over_current[1], 2'h0, next_open_flag[1],
                     next_over_current[0], 2'h0, next_open_flag[0]};
  assign next_b43 = {next_over_current[3], 2'h0, next_open_flag[3],
                     next_over_current[2], 2'h0, next_open_flag[2]};
  assign next_stat = {next_out_state, cmd_on};

  // read select, the last address falls through to the state register
  assign sel_top = (i_rd_addr == ADDR_TOP_PER_CHANNEL_DIAGNOSTIC_REGISTER);
  assign sel_b21 = (i_rd_addr == ADDR_PER_CHANNEL_DIAGNOSTIC_REGISTER_B21);
  assign sel_b43 = (i_rd_addr == ADDR_PER_CHANNEL_DIAGNOSTIC_REGISTER_B43);
  assign rd_mux = sel_top ? o_top_diagnostic_register
                : sel_b21 ? o_per_channel_diagnostic_register_b21
                : sel_b43 ? o_per_channel_diagnostic_register_b43
                : o_switch_output_state;

  // acknowledge of link words; the word stays put on the link side until this returns
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      link_ack <= 1'b0;
    end else if (new_word) begin
      link_ack <= req_sync;
    end
  end

  // silence watchdog, restarted by every good word
  // count stops at the limit so a long silence cannot wrap
  assign timed_out = (silence >= TO_W'(LINK_TIMEOUT));

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      silence <= '0;
    end else if (new_word && !link_word.bad) begin
      silence <= '0;
    end else if (!timed_out) begin
      silence <= silence + TO_W'(1);
    end
  end

  // heartbeat lets the switch side see that this side is alive
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      o_link_heartbeat <= 1'b0;
    end else if (new_word) begin
      o_link_heartbeat <= ~o_link_heartbeat;
    end
  end

  // chain address caught once after reset release
  // strap settles through its synchroniser before it is taken
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      strap_wait <= 2'h0;
      strap_taken <= 1'b0;
      chain_addr <= '0;
    end else if (!strap_taken) begin
      if (strap_wait == 2'h2) begin
        chain_addr <= strap_in;
        strap_taken <= 1'b1;
      end else begin
        strap_wait <= strap_wait + 2'h1;
      end
    end
  end

  // diagnostic state
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      state <= ST_RUN;
      open_flag <= '0;
      out_state <= '0;
      over_current <= '0;
    end else begin
      state <= next_state;
      open_flag <= next_open_flag;
      out_state <= next_out_state;
      over_current <= next_over_current;
    end
  end

  // readable registers
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      o_top_diagnostic_register <= REG_RESET;
      o_per_channel_diagnostic_register_b21 <= REG_RESET;
      o_per_channel_diagnostic_register_b43 <= REG_RESET;
      o_switch_output_state <= REG_RESET;
    end else begin
      o_top_diagnostic_register <= next_top;
      o_per_channel_diagnostic_register_b21 <= next_b21;
      o_per_channel_diagnostic_register_b43 <= next_b43;
      o_switch_output_state <= next_stat;
    end
  end

  // switch drive and indicator pins
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      o_switch_output_channel <= '0;
      o_open_load_indicator_pin_o <= 1'b0;
      o_open_load_indicator_pin_oe <= 1'b0;
      o_channel_state_indicator_pin_o <= '0;
      o_channel_state_indicator_pin_oe <= '0;
    end else begin
      o_switch_output_channel <= next_drive;
      o_open_load_indicator_pin_o <= 1'b0;
      o_open_load_indicator_pin_oe <= |next_open_flag;
      o_channel_state_indicator_pin_o <= '0;
      o_channel_state_indicator_pin_oe <= next_out_state;
    end
  end

  // read answers only when this device is addressed
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      o_rd_valid <= 1'b0;
      o_rd_data <= REG_RESET;
    end else begin
      o_rd_valid <= rd_hit;
      o_rd_data <= rd_hit ? rd_mux : REG_RESET;
    end
  end
endmodule : isd_top

// ===== src/isd_pkg.sv
// shared constants and types for the isolated switch diagnostic block
package isd_pkg;
  localparam int unsigned NCH = 4;
  localparam int unsigned CLK_SYS_PERIOD_NS = 8;
  // link silence that counts as loss of communication
  localparam int unsigned LINK_TIMEOUT_NS = 100000;
  localparam int unsigned LINK_TIMEOUT_CYC = LINK_TIMEOUT_NS / CLK_SYS_PERIOD_NS;
  // register addresses
  localparam logic [1:0] ADDR_TOP_PER_CHANNEL_DIAGNOSTIC_REGISTER = 2'h0;
  localparam logic [1:0] ADDR_PER_CHANNEL_DIAGNOSTIC_REGISTER_B21 = 2'h1;
  localparam logic [1:0] ADDR_PER_CHANNEL_DIAGNOSTIC_REGISTER_B43 = 2'h2;
  localparam logic [1:0] ADDR_SWITCH_OUTPUT_STATE = 2'h3;
  // field positions
  localparam int unsigned TOP_LINK_FAULT_BIT = 7;
  localparam int unsigned PER_CHANNEL_DIAGNOSTIC_REGISTER_OPEN_LO_BIT = 0;
  localparam int unsigned PER_CHANNEL_DIAGNOSTIC_REGISTER_OC_LO_BIT = 3;
  localparam int unsigned PER_CHANNEL_DIAGNOSTIC_REGISTER_OPEN_HI_BIT = 4;
  localparam int unsigned PER_CHANNEL_DIAGNOSTIC_REGISTER_OC_HI_BIT = 7;
  localparam int unsigned SWITCH_OUTPUT_STATE_LSB = 4;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int unsigned CHAIN_AW = 5;
  localparam int unsigned TO_W = 16;
  // frame sent by the switch side each link cycle it has news
  typedef struct packed {
    logic remote_err;
    logic [NCH-1:0] over_current;
    logic [NCH-1:0] open_meas;
    logic [NCH-1:0] out_state;
    logic parity;
  } isd_frame_type;
  // frame after the link-side check, passed into the system domain
  typedef struct packed {
    logic bad;
    isd_frame_type frame;
  } isd_word_type;
  localparam int unsigned WORD_W = $bits(isd_word_type);
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_FAULT = 3'b010,
    ST_HELD = 3'b100
  } isd_link_state_type;
endpackage : isd_pkg

// ===== src/isd_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/1ps
module isd_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset of the receiving domain
  input wire logic i_clk,
  input wire logic i_rstn,
  // level in and synchronised level out
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta;
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      meta <= '0;
      o_q <= '0;
    end else begin
      meta <= i_d;
      o_q <= meta;
    end
  end
endmodule : isd_sync

// ===== src/isd_link_rx.sv
// link-side frame receiver with parity check and toggle hand-over
`timescale 1ns/1ps
module isd_link_rx
  import isd_pkg::*;
(
  // link clock domain
  input wire logic i_clk_link,
  input wire logic i_rstn_link,
  // frame from the switch side
  input wire logic i_frame_valid,
  input wire isd_pkg::isd_frame_type i_frame,
  // hand-over towards the system domain
  input wire logic i_ack_sync,
  output logic o_req,
  output isd_pkg::isd_word_type o_word
);
  wire frame_bad;
  wire can_load;
  assign frame_bad = ^i_frame;
  // word stays stable until the system side has acknowledged it
  assign can_load = i_frame_valid && (o_req == i_ack_sync);
  always_ff @(posedge i_clk_link) begin
    if (!i_rstn_link) begin
      o_req <= 1'b0;
      o_word <= '0;
    end else if (can_load) begin
      o_word <= '{bad: frame_bad, frame: i_frame};
      o_req <= ~o_req;
    end
  end
endmodule : isd_link_rx

// ===== verif/isd_top_properties.sv
// concurrent checks on the ports of the diagnostic block
`timescale 1ns/1ps
module isd_top_checker
  import isd_pkg::*;
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  // inputs watched
  input wire logic [isd_pkg::NCH-1:0] i_switch_on_command,
  input wire logic [isd_pkg::NCH-1:0] i_parallel_channel_input,
  input wire logic [isd_pkg::CHAIN_AW-1:0] i_chain_addr_strap,
  input wire logic i_rd_en,
  input wire logic [isd_pkg::CHAIN_AW-1:0] i_rd_dev,
  input wire logic [1:0] i_rd_addr,
  input wire logic i_clr_en,
  // outputs watched
  input wire logic [isd_pkg::NCH-1:0] o_switch_output_channel,
  input wire logic o_rd_valid,
  input wire logic [7:0] o_rd_data,
  input wire logic [7:0] o_top_diagnostic_register,
  input wire logic [7:0] o_per_channel_diagnostic_register_b21,
  input wire logic [7:0] o_per_channel_diagnostic_register_b43,
  input wire logic [7:0] o_switch_output_state,
  input wire logic o_open_load_indicator_pin_o,
  input wire logic o_open_load_indicator_pin_oe,
  input wire logic [isd_pkg::NCH-1:0] o_channel_state_indicator_pin_o,
  input wire logic [isd_pkg::NCH-1:0] o_channel_state_indicator_pin_oe
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  wire logic fault = o_top_diagnostic_register[TOP_LINK_FAULT_BIT];
  wire logic any_open = o_per_channel_diagnostic_register_b21[0] | o_per_channel_diagnostic_register_b21[4] | o_per_channel_diagnostic_register_b43[0] | o_per_channel_diagnostic_register_b43[4];
  a_fault_outputs_off: assert property (fault |-> o_switch_output_channel == 4'h0)
    else $error("outputs driven during link fault");
  a_fault_state_zero: assert property (fault [*2] |-> o_switch_output_state[7:4] == 4'h0)
    else $error("output state shown on during link fault");
  a_clear_needed: assert property ($fell(fault) && $past(i_rstn) |-> $past(i_clr_en))
    else $error("link fault left without a clear");
  a_open_pin_set: assert property (any_open |-> ##[0:1] o_open_load_indicator_pin_oe)
    else $error("open-load pin not pulled low");
  a_open_pin_free: assert property (!any_open [*2] |-> !o_open_load_indicator_pin_oe)
    else $error("open-load pin low without a flag");
  a_pins_low_only: assert property (
    !o_open_load_indicator_pin_o && o_channel_state_indicator_pin_o == 4'h0)
    else $error("indicator drives high");
  a_on_no_open: assert property (
    i_switch_on_command[0] [*4] |-> !o_per_channel_diagnostic_register_b21[PER_CHANNEL_DIAGNOSTIC_REGISTER_OPEN_LO_BIT])
    else $error("open flag on a channel that is on");
  a_led_follows: assert property (
    $stable(o_switch_output_state[7:4]) [*3] |-> o_channel_state_indicator_pin_oe == o_switch_output_state[7:4])
    else $error("state pins differ from output state");
  a_cmd_reaches: assert property (
    (!fault && $stable(i_switch_on_command) && i_parallel_channel_input == 4'h0) [*6]
    |-> o_switch_output_channel == i_switch_on_command)
    else $error("drive differs from command");
  a_other_refused: assert property (
    i_rd_en && i_rd_dev != i_chain_addr_strap |=> !o_rd_valid && o_rd_data == 8'h00)
    else $error("read answered for another device");
  a_read_top: assert property (
    o_rd_valid && $past(i_rd_addr) == ADDR_TOP_PER_CHANNEL_DIAGNOSTIC_REGISTER
    |-> o_rd_data == $past(o_top_diagnostic_register))
    else $error("top register read wrong");
  a_read_state: assert property (
    o_rd_valid && $past(i_rd_addr) == ADDR_SWITCH_OUTPUT_STATE |-> o_rd_data == $past(o_switch_output_state))
    else $error("state register read wrong");
  c_fault: cover property ($rose(fault));
  c_open: cover property ($rose(o_open_load_indicator_pin_oe));
  c_read: cover property (o_rd_valid);
endmodule : isd_top_checker

bind isd_top isd_top_checker u_chk (.i_clk_sys, .i_rstn, .i_switch_on_command,
  .i_parallel_channel_input, .i_chain_addr_strap, .i_rd_en, .i_rd_dev, .i_rd_addr, .i_clr_en,
  .o_switch_output_channel, .o_rd_valid, .o_rd_data, .o_top_diagnostic_register, .o_per_channel_diagnostic_register_b21,
  .o_per_channel_diagnostic_register_b43, .o_switch_output_state, .o_open_load_indicator_pin_o, .o_open_load_indicator_pin_oe,
  .o_channel_state_indicator_pin_o, .o_channel_state_indicator_pin_oe);

// ===== verif/isd_switch_model.sv
// switch-side frame source standing in for the isolated half
`timescale 1ns/1ps
module isd_switch_model
  import isd_pkg::*;
(
  // link clock
  input wire logic i_clk_link,
  // frames towards the logic side
  output logic o_frame_valid,
  output isd_pkg::isd_frame_type o_frame
);
  logic alive = 1'b1;
  logic rerr = 1'b0;
  logic badpar = 1'b0;
  logic [NCH-1:0] oc = 4'h0;
  logic [NCH-1:0] opn = 4'h0;
  logic [NCH-1:0] st = 4'h0;
  initial begin
    o_frame_valid = 1'b0;
    o_frame = '0;
  end
  // one frame every nine link cycles while powered
  always begin
    repeat (8) @(posedge i_clk_link);
    if (alive) begin
      #1;
      o_frame_valid = 1'b1;
      o_frame = {rerr, oc, opn, st, ^{rerr, oc, opn, st} ^ badpar};
      @(posedge i_clk_link);
      #1;
      o_frame_valid = 1'b0;
      // idle bus never shows a stale frame
      o_frame = ~o_frame;
    end
  end
endmodule : isd_switch_model

// ===== verif/tb.sv
// self-checking bench for the isolated switch diagnostic block
`timescale 1ns/1ps
module tb;
  import isd_pkg::*;
  localparam int unsigned TO = 50;
  localparam logic [4:0] DEV = 5'h13;
  logic clk_sys = 1'b0;
  logic clk_link = 1'b0;
  logic rstn = 1'b0;
  logic rstn_link = 1'b0;
  logic frame_valid, heartbeat, rd_valid, open_o, open_oe;
  isd_frame_type frame;
  logic [NCH-1:0] pins = 4'h0;
  logic [NCH-1:0] cmd = 4'h0;
  logic [NCH-1:0] out_ch, led_o, led_oe;
  logic rd_en = 1'b0;
  logic clr_en = 1'b0;
  logic [4:0] rd_dev = 5'h00;
  logic [4:0] clr_dev = 5'h00;
  logic [1:0] rd_addr = 2'h0;
  logic [7:0] rd_data, top, b21, b43, switch_output_state;
  int err_count = 0;
  int check_count = 0;
  always #4 clk_sys = ~clk_sys;
  initial begin
    #3;
    forever #16 clk_link = ~clk_link;
  end
  isd_switch_model sw (.i_clk_link(clk_link), .o_frame_valid(frame_valid), .o_frame(frame));
  isd_top #(.LINK_TIMEOUT(TO)) uut (.i_clk_sys(clk_sys), .i_rstn(rstn), .i_clk_link(clk_link),
    .i_rstn_link(rstn_link), .i_frame_valid(frame_valid), .i_frame(frame),
    .o_link_heartbeat(heartbeat), .i_parallel_channel_input(pins), .i_switch_on_command(cmd),
    .o_switch_output_channel(out_ch), .i_chain_addr_strap(DEV), .i_rd_en(rd_en),
    .i_rd_dev(rd_dev), .i_rd_addr(rd_addr), .o_rd_valid(rd_valid), .o_rd_data(rd_data),
    .i_clr_en(clr_en), .i_clr_dev(clr_dev), .o_top_diagnostic_register(top),
    .o_per_channel_diagnostic_register_b21(b21), .o_per_channel_diagnostic_register_b43(b43), .o_switch_output_state(switch_output_state),
    .o_open_load_indicator_pin_o(open_o), .o_open_load_indicator_pin_oe(open_oe),
    .o_channel_state_indicator_pin_o(led_o), .o_channel_state_indicator_pin_oe(led_oe));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc
  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // waits for words taken in the system domain
  task automatic wait_words(input int n);
    int k;
    logic hb;
    k = 0;
    repeat (n) begin
      hb = heartbeat;
      while (heartbeat === hb && k < 400) begin
        cyc(1);
        k++;
      end
    end
    if (k >= 400) begin
      err_count++;
      $display("ERROR heartbeat expected toggle seen none");
      finish_test();
    end
    cyc(4);
  endtask : wait_words
  task automatic rd(input logic [4:0] dev, input logic [1:0] a, input logic v,
                    input logic [7:0] d);
    rd_en = 1'b1;
    rd_dev = dev;
    rd_addr = a;
    cyc(1);
    rd_en = 1'b0;
    check("rd_valid", {7'h00, rd_valid}, {7'h00, v});
    check("rd_data", rd_data, d);
    cyc(1);
  endtask : rd
  task automatic clr();
    clr_en = 1'b1;
    clr_dev = DEV;
    cyc(1);
    clr_en = 1'b0;
    cyc(3);
  endtask : clr
  task automatic t_reset();
    cyc(4);
    check("top", top, REG_RESET);
    check("b21", b21, REG_RESET);
    check("switch_output_state", switch_output_state, REG_RESET);
    rd(5'h04, ADDR_TOP_PER_CHANNEL_DIAGNOSTIC_REGISTER, 1'b0, 8'h00);
    wait_words(2);
    clr();
    check("fault", {7'h00, top[7]}, 8'h00);
  endtask : t_reset
  task automatic t_open();
    sw.opn = 4'h5;
    wait_words(3);
    check("b21", b21, 8'h01);
    check("b43", b43, 8'h01);
    check("open_oe", {7'h00, open_oe}, 8'h01);
    check("open_o", {7'h00, open_o}, 8'h00);
    rd(DEV, ADDR_PER_CHANNEL_DIAGNOSTIC_REGISTER_B21, 1'b1, 8'h01);
    cmd = 4'h5;
    wait_words(3);
    check("b21", b21, 8'h00);
    check("b43", b43, 8'h00);
    check("open_oe", {7'h00, open_oe}, 8'h00);
    sw.opn = 4'h0;
  endtask : t_open
  task automatic t_status();
    pins = 4'hA;
    sw.st = 4'hF;
    wait_words(3);
    check("out", {4'h0, out_ch}, 8'h0F);
    check("switch_output_state", switch_output_state, 8'hFF);
    sw.oc = 4'h4;
    sw.st = 4'hB;
    wait_words(3);
    check("led_oe", {4'h0, led_oe}, 8'h0B);
    check("switch_output_state", switch_output_state, 8'hBF);
    check("b43", b43, 8'h08);
    check("led_o", {4'h0, led_o}, 8'h00);
    sw.oc = 4'h0;
    sw.st = 4'hF;
    wait_words(3);
    check("led_oe", {4'h0, led_oe}, 8'h0F);
    pins = 4'h0;
    cmd = 4'hF;
  endtask : t_status
  task automatic t_fault();
    clr();
    sw.badpar = 1'b1;
    wait_words(2);
    check("fault", {7'h00, top[7]}, 8'h01);
    check("out", {4'h0, out_ch}, 8'h00);
    check("switch_output_state", switch_output_state, 8'h0F);
    sw.badpar = 1'b0;
    wait_words(2);
    check("fault", {7'h00, top[7]}, 8'h01);
    check("out", {4'h0, out_ch}, 8'h00);
    clr_en = 1'b1;
    clr_dev = 5'h04;
    cyc(1);
    clr_en = 1'b0;
    cyc(3);
    check("fault", {7'h00, top[7]}, 8'h01);
    clr();
    check("fault", {7'h00, top[7]}, 8'h00);
    check("out", {4'h0, out_ch}, 8'h0F);
    sw.rerr = 1'b1;
    wait_words(2);
    check("fault", {7'h00, top[7]}, 8'h01);
    sw.rerr = 1'b0;
    wait_words(2);
    clr();
  endtask : t_fault
  task automatic t_dead();
    sw.alive = 1'b0;
    cyc(TO + 10);
    check("fault", {7'h00, top[7]}, 8'h01);
    check("out", {4'h0, out_ch}, 8'h00);
    sw.alive = 1'b1;
    wait_words(2);
    clr();
    rd(DEV, ADDR_TOP_PER_CHANNEL_DIAGNOSTIC_REGISTER, 1'b1, 8'h00);
    rd(DEV, ADDR_SWITCH_OUTPUT_STATE, 1'b1, 8'h0F);
    wait_words(1);
    rd(DEV, ADDR_SWITCH_OUTPUT_STATE, 1'b1, 8'hFF);
    rd(5'h04, ADDR_SWITCH_OUTPUT_STATE, 1'b0, 8'h00);
  endtask : t_dead
  initial begin
    repeat (4) @(posedge clk_link);
    #1;
    rstn_link = 1'b1;
  end
  initial begin
    cyc(8);
    rstn = 1'b1;
    t_reset();
    t_open();
    t_status();
    t_fault();
    t_dead();
    finish_test();
  end
endmodule : tb
